//--- core/scp_pkg.sv
`default_nettype none
// ============================================================
// Shared constants for the system clock prescaler block
package scp_pkg;

	// ============================================================
	// Register byte offsets on the Avalon-MM slave
	localparam logic [3:0] SCP_OFF_DIVIDE_CONTROL = 4'h0;    // Divide control and unlock flag
	localparam logic [3:0] SCP_OFF_TRIM           = 4'h4;    // RC oscillator trim
	localparam logic [3:0] SCP_OFF_DIVIDE_STATUS  = 4'h8;    // Active divider state, read only

	// ============================================================
	// Field positions
	localparam int SCP_UNLOCK_BIT      = 7;                  // Change-unlock flag in divide control
	localparam int SCP_SELECT_MSB      = 3;                  // Top bit of the select field
	localparam int SCP_OTHER_MSB       = 6;                  // Top bit of the non-unlock bits
	localparam int SCP_TRIM_RANGE_BIT  = 7;                  // Range bit of the trim value
	localparam int SCP_TRIM_FINE_MSB   = 6;                  // Top bit of the fine tune field
	localparam int SCP_PENDING_BIT     = 4;                  // Switch pending bit in divide status

	// ============================================================
	// Field values
	localparam logic [3:0] SCP_SELECT_MAX_CODE    = 4'h8;    // Divide by 256; above is reserved
	localparam logic [3:0] SCP_SELECT_RESET_PLAIN = 4'h0;    // Reset select, fuse unprogrammed
	localparam logic [3:0] SCP_SELECT_RESET_FUSED = 4'h3;    // Reset select, divide by eight
	localparam logic [6:0] SCP_OTHER_ZERO         = 7'h00;   // Non-unlock bits of an unlock write

	// ============================================================
	// Timing
	localparam logic [2:0] SCP_UNLOCK_WINDOW      = 3'h4;    // Unlock window length in clocks

	// ============================================================
	// Avalon-MM response codes
	localparam logic [1:0] SCP_RESP_OKAY          = 2'h0;    // Normal answer
	localparam logic [1:0] SCP_RESP_SLVERR        = 2'h2;    // Unmapped address

	// ============================================================
	// Bus access states
	typedef enum logic {
		scp_bus_idle,                                        // Waiting, request held off
		scp_bus_answer                                       // Answer cycle, waitrequest low
	} scp_bus_state_t;

endpackage
`default_nettype wire

//--- core/scp_divider.sv
`default_nettype none
// ============================================================
// Power-of-two divider with switch-at-period-end and gated clock
module scp_divider #(
	parameter int SEL_W = 4,                                 // Select code width
	parameter int CNT_W = 8                                  // Counter width, largest factor 256
) (
	input  wire logic             mclk,                      // Undivided source clock
	input  wire logic             srst,                      // Synchronous reset
	input  wire logic [SEL_W-1:0] reset_select,              // Select code used during reset
	input  wire logic [SEL_W-1:0] requested_select,          // Select code wanted by software
	output logic      [SEL_W-1:0] active_select,             // Select code now in force
	output logic                  switch_pending,            // Requested differs from active
	output logic                  system_tick,               // High in the mclk cycle of each edge
	output logic                  divided_clock              // Glitch-free divided clock
);

	logic [CNT_W-1:0] count;                                 // Cycles left in the current period
	logic             gate;                                  // Clock gate, changes while mclk low
	logic [CNT_W:0]   period_span;                           // Factor of the requested code

	// End of the current divided period
	assign system_tick    = (count == '0);
	assign switch_pending = (requested_select != active_select);
	assign period_span    = (CNT_W+1)'(1) << requested_select;

	// ============================================================
	// Counter on the undivided clock; a new factor loads only at a period end
	always_ff @(posedge mclk) begin
		if (srst) begin
			count         <= '0;
			active_select <= reset_select;
		end else if (system_tick) begin
			// Old period finished: start a full period of the new factor
			count         <= CNT_W'(period_span - (CNT_W+1)'(1));
			active_select <= requested_select;
		end else begin
			count         <= count - CNT_W'(1);
		end
	end

	// ============================================================
	// Gate sampled while mclk is low, so each pulse is a whole mclk high phase
	always_ff @(negedge mclk) begin
		if (srst) begin
			gate <= 1'b1;
		end else begin
			gate <= system_tick;
		end
	end

	// Only whole high phases pass; no runt pulse can form
	assign divided_clock = mclk & gate;

endmodule
`default_nettype wire

//--- core/scp_trim.sv
`default_nettype none
// ============================================================
// RC oscillator trim register
module scp_trim #(
	parameter int TRIM_W = 8                                 // Trim register width
) (
	input  wire logic              mclk,                     // Source clock
	input  wire logic              srst,                     // Synchronous chip reset
	input  wire logic [TRIM_W-1:0] factory_trim,             // Factory calibration byte
	input  wire logic              write_strobe,             // Software write, one cycle
	input  wire logic [TRIM_W-1:0] write_value,              // Value written by software
	output logic      [TRIM_W-1:0] trim_value,               // Whole trim value
	output logic                   trim_range_select,        // Low or high overlapping range
	output logic      [TRIM_W-2:0] trim_fine_tune            // Monotone tune within range
);

	// ============================================================
	// Factory byte loads at reset, software may rewrite at any time
	always_ff @(posedge mclk) begin
		if (srst) begin
			trim_value <= factory_trim;
		end else if (write_strobe) begin
			trim_value <= write_value;
		end
	end

	// Fields go straight to the oscillator with no extra delay
	assign trim_range_select = trim_value[scp_pkg::SCP_TRIM_RANGE_BIT];
	assign trim_fine_tune    = trim_value[scp_pkg::SCP_TRIM_FINE_MSB:0];

endmodule
`default_nettype wire

//--- core/scp_clock_prescaler.sv
`default_nettype none
// ============================================================
// System clock prescaler and RC trim, Avalon-MM slave
module scp_clock_prescaler #(
	parameter int SEL_W  = 4,                                // Select code width
	parameter int CNT_W  = 8,                                // Divider counter width
	parameter int TRIM_W = 8                                 // Trim register width
) (
	input  wire logic              mclk,                     // Undivided source clock
	input  wire logic              srst,                     // Synchronous chip reset
	input  wire logic [3:0]        avs_address,              // Byte address
	input  wire logic              avs_read,                 // Read request
	input  wire logic              avs_write,                // Write request
	input  wire logic [31:0]       avs_writedata,            // Write data
	input  wire logic [3:0]        avs_byteenable,           // Byte lanes of a write
	output logic      [31:0]       avs_readdata,             // Read data
	output logic      [1:0]        avs_response,             // Answer status
	output logic                   avs_waitrequest,          // Holds the master off
	input  wire logic              reset_divide_by_eight_fuse, // High when fuse programmed
	input  wire logic [TRIM_W-1:0] factory_trim,             // Factory calibration byte
	output logic                   processor_clock,          // Divided CPU clock
	output logic                   program_memory_clock,     // Divided flash clock
	output logic                   peripheral_io_clock,      // Divided I/O clock
	output logic                   converter_clock,          // Divided ADC clock
	output logic                   system_tick,              // One mclk cycle per divided edge
	output logic                   trim_range_select,        // Oscillator range
	output logic      [TRIM_W-2:0] trim_fine_tune            // Oscillator fine tune
);

	// ============================================================
	// Declarations
	scp_pkg::scp_bus_state_t state;                          // Bus access state
	scp_pkg::scp_bus_state_t next_state;                     // Next bus access state
	logic              bus_request;                          // Read or write held by master
	logic              write_commit;                         // Write takes effect at this edge
	logic              control_write;                        // Committed write to divide control
	logic              unlock_write;                         // Write of the unlock pattern
	logic              select_write;                         // Write with the unlock bit clear
	logic              trim_write;                           // Committed write to the trim
	logic              select_code_valid;                    // Written code is not reserved
	logic              divide_change_unlock;                 // Unlock flag, bit seven
	logic [2:0]        unlock_age;                           // Cycles since the flag was set
	logic [SEL_W-1:0]  divide_select;                        // Select code held for software
	logic [SEL_W-1:0]  reset_select;                         // Select code chosen by the fuse
	logic [SEL_W-1:0]  active_select;                        // Select code now in force
	logic              switch_pending;                       // New code not yet in force
	logic              divided_clock;                        // Shared divided clock
	logic [TRIM_W-1:0] trim_value;                           // Trim register contents

	// ============================================================
	// Bus handshake
	// Every access spends one cycle with waitrequest high, then one without
	assign bus_request     = avs_read | avs_write;
	assign avs_waitrequest = bus_request & (state == scp_pkg::scp_bus_idle);
	assign write_commit    = avs_write & (state == scp_pkg::scp_bus_answer);

	// Next state of the access sequence
	always_comb begin
		next_state = state;
		case (state)
			scp_pkg::scp_bus_idle: begin
				// A held request moves on to its answer cycle
				if (bus_request) begin
					next_state = scp_pkg::scp_bus_answer;
				end
			end
			scp_pkg::scp_bus_answer: begin
				// The master releases after this edge
				next_state = scp_pkg::scp_bus_idle;
			end
			default: begin
				next_state = scp_pkg::scp_bus_idle;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= scp_pkg::scp_bus_idle;
		end else begin
			state <= next_state;
		end
	end

	// ============================================================
	// Read data and response, captured in the waiting cycle
	// They stand through the answer cycle, where the master takes them
	always_ff @(posedge mclk) begin
		if (srst) begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= scp_pkg::SCP_RESP_OKAY;
		end else if (bus_request && state == scp_pkg::scp_bus_idle) begin
			// Address decode; unused bits read as zero
			if (avs_address == scp_pkg::SCP_OFF_DIVIDE_CONTROL) begin
				avs_readdata <= 32'({divide_change_unlock, 3'h0, divide_select});
				avs_response <= scp_pkg::SCP_RESP_OKAY;
			end else if (avs_address == scp_pkg::SCP_OFF_TRIM) begin
				avs_readdata <= 32'(trim_value);
				avs_response <= scp_pkg::SCP_RESP_OKAY;
			end else if (avs_address == scp_pkg::SCP_OFF_DIVIDE_STATUS) begin
				avs_readdata <= 32'({switch_pending, active_select});
				avs_response <= scp_pkg::SCP_RESP_OKAY;
			end else begin
				// Unmapped: zero data and an error answer
				avs_readdata <= 32'h0000_0000;
				avs_response <= scp_pkg::SCP_RESP_SLVERR;
			end
		end
	end

	// ============================================================
	// Write decode
	// All fields sit in the low byte lane, so byte zero must be enabled
	assign control_write = write_commit & avs_byteenable[0]
		& (avs_address == scp_pkg::SCP_OFF_DIVIDE_CONTROL);
	assign trim_write    = write_commit & avs_byteenable[0]
		& (avs_address == scp_pkg::SCP_OFF_TRIM);

	// Unlock pattern: bit seven set and bits six to zero clear
	assign unlock_write  = control_write & avs_writedata[scp_pkg::SCP_UNLOCK_BIT]
		& (avs_writedata[scp_pkg::SCP_OTHER_MSB:0] == scp_pkg::SCP_OTHER_ZERO);

	// Select attempt: the unlock bit written as zero
	assign select_write  = control_write & ~avs_writedata[scp_pkg::SCP_UNLOCK_BIT];

	// Codes above divide-by-256 are reserved
	assign select_code_valid = (avs_writedata[scp_pkg::SCP_SELECT_MSB:0]
		<= scp_pkg::SCP_SELECT_MAX_CODE);

	// ============================================================
	// Unlock flag and its four-cycle window
	// A write with bit seven set and other bits nonzero leaves it alone
	always_ff @(posedge mclk) begin
		if (srst) begin
			divide_change_unlock <= 1'b0;
			unlock_age           <= 3'h0;
		end else if (divide_change_unlock) begin
			// Open window: a rewrite of the pattern changes nothing
			if (select_write) begin
				divide_change_unlock <= 1'b0;
				unlock_age           <= 3'h0;
			end else if (unlock_age == scp_pkg::SCP_UNLOCK_WINDOW - 3'h1) begin
				divide_change_unlock <= 1'b0;
				unlock_age           <= 3'h0;
			end else begin
				unlock_age <= unlock_age + 3'h1;
			end
		end else if (unlock_write) begin
			// Closed: only the clean pattern opens the window
			divide_change_unlock <= 1'b1;
			unlock_age           <= 3'h0;
		end
	end

	// ============================================================
	// Select code held for software
	// Reset value follows the fuse; afterwards only unlocked writes count
	assign reset_select = reset_divide_by_eight_fuse ? scp_pkg::SCP_SELECT_RESET_FUSED
		: scp_pkg::SCP_SELECT_RESET_PLAIN;

	always_ff @(posedge mclk) begin
		if (srst) begin
			divide_select <= reset_select;
		end else if (select_write && divide_change_unlock && select_code_valid) begin
			// Any valid code, whatever the fuse says
			divide_select <= avs_writedata[scp_pkg::SCP_SELECT_MSB:0];
		end
		// Locked or reserved writes keep the old code
	end

	// ============================================================
	// Divider: switches only at the end of the running period
	scp_divider #(
		.SEL_W            (SEL_W),
		.CNT_W            (CNT_W)
	) u_divider (
		.mclk             (mclk),
		.srst             (srst),
		.reset_select     (reset_select),
		.requested_select (divide_select),
		.active_select    (active_select),
		.switch_pending   (switch_pending),
		.system_tick      (system_tick),
		.divided_clock    (divided_clock)
	);

	// One divided clock for every synchronous domain
	assign processor_clock      = divided_clock;
	assign program_memory_clock = divided_clock;
	assign peripheral_io_clock  = divided_clock;
	assign converter_clock      = divided_clock;

	// ============================================================
	// Oscillator trim
	scp_trim #(
		.TRIM_W            (TRIM_W)
	) u_trim (
		.mclk              (mclk),
		.srst              (srst),
		.factory_trim      (factory_trim),
		.write_strobe      (trim_write),
		.write_value       (avs_writedata[TRIM_W-1:0]),
		.trim_value        (trim_value),
		.trim_range_select (trim_range_select),
		.trim_fine_tune    (trim_fine_tune)
	);

endmodule
`default_nettype wire

//--- sim/scp_clock_prescaler_asserts.sv
`default_nettype none
// ============================================================
// Port-level checks for the clock prescaler
module scp_clock_prescaler_asserts #(
	parameter int TRIM_W = 8                     // Trim register width
) (
	input wire logic              mclk,           // Source clock
	input wire logic              srst,           // Chip reset
	input wire logic [3:0]        avs_address,    // Bus address
	input wire logic              avs_read,       // Read request
	input wire logic              avs_write,      // Write request
	input wire logic [31:0]       avs_writedata,  // Write data
	input wire logic [3:0]        avs_byteenable, // Byte lanes
	input wire logic [31:0]       avs_readdata,   // Read data
	input wire logic              avs_waitrequest,// Wait
	input wire logic              processor_clock,
	input wire logic              program_memory_clock,
	input wire logic              peripheral_io_clock,
	input wire logic              converter_clock,
	input wire logic              system_tick,    // Divided edge marker
	input wire logic              trim_range_select,
	input wire logic [TRIM_W-2:0] trim_fine_tune
);
	// ============================================================
	// Helper terms
	logic       req;                             // Any request
	logic       trim_wr;                         // Trim write commits now
	logic       rd_ans;                          // Read answered now
	logic [8:0] tick_gap;                        // Cycles since last tick
	assign req     = avs_read | avs_write;
	assign trim_wr = avs_write && !avs_waitrequest && avs_address == scp_pkg::SCP_OFF_TRIM && avs_byteenable[0];
	assign rd_ans  = avs_read && !avs_waitrequest;
	// Gap counter, cleared by each tick
	always_ff @(posedge mclk) begin
		if (srst || system_tick) begin
			tick_gap <= 9'h000;
		end else begin
			tick_gap <= tick_gap + 9'h001;
		end
	end
	// ============================================================
	// Sequences of the unlock window
	sequence unlock_commit;
		avs_write && !avs_waitrequest && avs_address == scp_pkg::SCP_OFF_DIVIDE_CONTROL
			&& avs_byteenable[0] && avs_writedata[7:0] == 8'h80;
	endsequence
	sequence ctrl_answer;
		rd_ans && avs_address == scp_pkg::SCP_OFF_DIVIDE_CONTROL;
	endsequence
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ============================================================
	// Assertions
	wait_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest || !req)
		else $error("bus answer late");
	idle_release_a: assert property (!req |-> !avs_waitrequest)
		else $error("wait raised without request");
	trim_follow_a: assert property (trim_wr |=> {trim_range_select, trim_fine_tune} == $past(avs_writedata[TRIM_W-1:0]))
		else $error("trim outputs not updated");
	trim_hold_a: assert property (!trim_wr |=> $stable({trim_range_select, trim_fine_tune}))
		else $error("trim outputs moved without write");
	clocks_match_a: assert property (@(negedge mclk) disable iff (srst)
		processor_clock == program_memory_clock && processor_clock == peripheral_io_clock
		&& processor_clock == converter_clock)
		else $error("divided clocks differ");
	clock_pulse_a: assert property (@(negedge mclk) disable iff (srst)
		processor_clock == $past(system_tick))
		else $error("divided pulse not after tick");
	ctrl_pad_a: assert property (ctrl_answer |-> avs_readdata[6:4] == 3'h0 && avs_readdata[31:8] == 24'h00_0000)
		else $error("control pad bits not zero");
	status_code_a: assert property (rd_ans && avs_address == scp_pkg::SCP_OFF_DIVIDE_STATUS
		|-> avs_readdata[3:0] <= scp_pkg::SCP_SELECT_MAX_CODE)
		else $error("active code reserved");
	tick_gap_a: assert property (tick_gap <= 9'h0ff)
		else $error("divided period too long");
	unlock_expire_a: assert property (unlock_commit ##1 (!avs_write) [*6] ##1 ctrl_answer |-> !avs_readdata[7])
		else $error("unlock flag did not expire");
endmodule
bind scp_clock_prescaler scp_clock_prescaler_asserts #(.TRIM_W(TRIM_W)) chk_u (
	.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .processor_clock(processor_clock),
	.program_memory_clock(program_memory_clock), .peripheral_io_clock(peripheral_io_clock),
	.converter_clock(converter_clock), .system_tick(system_tick),
	.trim_range_select(trim_range_select), .trim_fine_tune(trim_fine_tune)
);
`default_nettype wire

//--- sim/scp_clock_prescaler_tb_top.sv
`default_nettype none
// ============================================================
// Self-checking bench for the clock prescaler
module scp_clock_prescaler_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, srst, avs_read, avs_write, avs_waitrequest, fuse;   // Clock, reset, bus control
	logic [3:0]  avs_address, avs_byteenable;                              // Address and lanes
	logic [31:0] avs_writedata, avs_readdata, rd;                          // Data, last read
	logic [1:0]  avs_response, rs;                                         // Status, last status
	logic [7:0]  factory_trim, trim_exp;                                   // Factory and expected trim
	logic        cpu_clk, mem_clk, io_clk, adc_clk, system_tick, trim_range_select;
	logic [6:0]  trim_fine_tune;                                           // Fine tune output
	logic [3:0]  sel, code;                                                // Expected and written select
	int          mismatches, cmp_count, gap, t1;                           // Counters and spans
	localparam logic [3:0] CTRL = scp_pkg::SCP_OFF_DIVIDE_CONTROL;         // Control offset
	scp_clock_prescaler dut_u (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
		.reset_divide_by_eight_fuse(fuse), .factory_trim(factory_trim), .processor_clock(cpu_clk),
		.program_memory_clock(mem_clk), .peripheral_io_clock(io_clk), .converter_clock(adc_clk),
		.system_tick(system_tick), .trim_range_select(trim_range_select), .trim_fine_tune(trim_fine_tune));
	// Source clock, 50 ns period
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ============================================================
	// Compare and closing tasks
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_ok(input logic ok);
		cmp_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: timing out of range", $time);
		end
	endtask
	task automatic test_done;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ============================================================
	// Bus access: hold until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= {3'b000, be};
		avs_read <= !wr;
		avs_write <= wr;
		while (!ok) begin
			// Answer and read data are taken at the rising edge only
			@(posedge mclk);
			ok = (avs_waitrequest === 1'b0);
			rd = avs_readdata;
			rs = avs_response;
			n++;
			if (n > 20) begin
				mismatches++;
				test_done();
			end
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Reset with a given fuse level and a random factory byte
	task automatic do_reset(input logic f);
		logic [7:0] v;
		v = 8'($urandom);
		@(posedge mclk);
		srst <= 1'b1;
		fuse <= f;
		factory_trim <= v;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		sel = f ? 4'h3 : 4'h0;
		trim_exp = v;
	endtask
	// Count cycles up to the given number of ticks
	task automatic tick_span(input int ticks, output int n);
		n = 0;
		repeat (ticks) begin
			do begin
				@(negedge mclk);
				n++;
			end while (system_tick !== 1'b1 && n < 2000);
		end
	endtask
	// Unlock then select after some idle cycles
	task automatic change(input int idle, input logic [3:0] c);
		bus(1'b1, CTRL, 8'h80, 1'b1);
		repeat (idle) @(posedge mclk);
		bus(1'b1, CTRL, {4'h0, c}, 1'b1);
	endtask
	// Watchdog
	initial begin
		repeat (90000) @(posedge mclk);
		mismatches++;
		test_done();
	end
	// ============================================================
	// Main sequence
	initial begin
		srst = 1'b1;
		fuse = 1'b0;
		factory_trim = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		mismatches = 0;
		cmp_count = 0;
		void'($urandom(32'hf9238da8));
		for (int f = 1; f >= 0; f--) begin
			do_reset(f[0]);
			bus(1'b0, CTRL, 8'h00, 1'b1);
			chk_reg(rd, {24'h00_0000, 4'h0, sel});
			bus(1'b0, scp_pkg::SCP_OFF_TRIM, 8'h00, 1'b1);
			chk_reg(rd, {24'h00_0000, trim_exp});
		end
		// Unmapped place answers with an error and reads zero
		bus(1'b1, 4'hc, 8'hff, 1'b1);
		bus(1'b0, 4'hc, 8'h00, 1'b1);
		chk_reg({rd[31:2], rs}, {30'h0000_0000, scp_pkg::SCP_RESP_SLVERR});
		// Locked select write, then a dirty unlock pattern
		bus(1'b1, CTRL, 8'h05, 1'b1);
		bus(1'b1, CTRL, 8'h81, 1'b1);
		bus(1'b0, CTRL, 8'h00, 1'b1);
		chk_reg(rd, 32'h0000_0000);
		// Flag visible, then expired
		bus(1'b1, CTRL, 8'h80, 1'b1);
		bus(1'b0, CTRL, 8'h00, 1'b1);
		chk_reg(rd, 32'h0000_0080);
		bus(1'b1, CTRL, 8'h80, 1'b1);
		repeat (4) @(posedge mclk);
		bus(1'b0, CTRL, 8'h00, 1'b1);
		chk_reg(rd, 32'h0000_0000);
		// Window edge: last cycle accepted, one later refused
		for (int k = 1; k <= 2; k++) begin
			change(k, 4'(k + 4));
			if (k == 1) sel = 4'h5;
			bus(1'b0, CTRL, 8'h00, 1'b1);
			chk_reg(rd, {24'h00_0000, 4'h0, sel});
		end
		// Rewriting the flag does not restart the window
		bus(1'b1, CTRL, 8'h80, 1'b1);
		change(0, 4'h7);
		bus(1'b0, CTRL, 8'h00, 1'b1);
		chk_reg(rd, {24'h00_0000, 4'h0, sel});
		// Every code once, then random codes, with random trim writes
		for (int i = 0; i < 22; i++) begin
			code = (i < 16) ? 4'(i) : 4'($urandom % 16);
			t1 = 1 << sel;
			change(0, code);
			if (code <= 4'h8) sel = code;
			tick_span(2, gap);
			chk_ok(gap <= t1 + 2 * (1 << sel));
			tick_span(1, gap);
			chk_ok(gap == (1 << sel));
			bus(1'b0, CTRL, 8'h00, 1'b1);
			chk_reg(rd, {24'h00_0000, 4'h0, sel});
			bus(1'b0, scp_pkg::SCP_OFF_DIVIDE_STATUS, 8'h00, 1'b1);
			chk_reg(rd, {24'h00_0000, 4'h0, sel});
			code = 4'($urandom);
			bus(1'b1, scp_pkg::SCP_OFF_TRIM, {code, 4'(i)}, code[0]);
			if (code[0]) trim_exp = {code, 4'(i)};
			// Trim outputs settle after the commit edge
			@(negedge mclk);
			chk_reg({24'h00_0000, trim_range_select, trim_fine_tune}, {24'h00_0000, trim_exp});
		end
		test_done();
	end
endmodule
`default_nettype wire
